// ==== design/aocos_pkg.sv ====
package aocos_pkg;

  // Clock and sample timing
  localparam int unsigned CLK_KHZ      = 125000;
  localparam int unsigned SAMPLE_US    = 16;
  localparam int unsigned SAMPLE_CYC   = SAMPLE_US * CLK_KHZ / 1000;
  localparam int unsigned INTERP_STEPS = 16;
  localparam int unsigned STEP_CYC     = SAMPLE_CYC / INTERP_STEPS;
  localparam int unsigned PCM_KHZ      = 4000;
  localparam int unsigned PCM_CYC      = CLK_KHZ / PCM_KHZ;

  // Startup phase lengths
  localparam int unsigned PH1_MS        = 80;
  localparam int unsigned PH2_MS        = 70;
  localparam int unsigned ST_MS         = 96;
  localparam int unsigned PH1_CYC       = PH1_MS * CLK_KHZ;
  localparam int unsigned PH2_CYC       = PH2_MS * CLK_KHZ;
  localparam int unsigned ST_CYC        = ST_MS * CLK_KHZ;
  localparam int unsigned ST_MAX_REPEAT = 6;
  localparam int unsigned PHW           = 24;

  // Offset filter coefficients, 24 fractional bits; numerator taps are half of the A coefficient
  localparam int unsigned       COEF_FRAC = 24;
  localparam int unsigned       YF        = 16;
  localparam int unsigned       YW        = 44;
  localparam logic signed [25:0] A_10HZ   = 26'sh00415c1;
  localparam logic signed [25:0] B_10HZ   = 26'sh0fbea3f;
  localparam logic signed [25:0] A_0P3HZ  = 26'sh0001f9d;
  localparam logic signed [25:0] B_0P3HZ  = 26'sh0ffe063;
  localparam logic signed [25:0] A_0P1HZ  = 26'sh0000a8a;
  localparam logic signed [25:0] B_0P1HZ  = 26'sh0fff576;

  // Output scaling: lowest kept bit of each word size
  localparam int unsigned LSB10 = 12;
  localparam int unsigned LSB8  = 14;

  localparam int unsigned MON_W = 8;

  // Register map (byte addresses)
  localparam logic [7:0] ADDR_CFG2   = 8'h00;
  localparam logic [7:0] ADDR_CFG3   = 8'h04;
  localparam logic [7:0] ADDR_CTRL   = 8'h08;
  localparam logic [7:0] ADDR_STAT   = 8'h0c;
  localparam logic [7:0] ADDR_IRQ    = 8'h10;
  localparam logic [7:0] ADDR_MASK   = 8'h14;
  localparam logic [7:0] ADDR_MONLIM = 8'h18;
  localparam logic [7:0] ADDR_STEP   = 8'h1c;
  localparam logic [7:0] ADDR_RATE   = 8'h20;
  localparam logic [7:0] ADDR_OFFLIM = 8'h24;
  localparam logic [7:0] ADDR_DATA   = 8'h28;

  // Field positions
  localparam int unsigned CFG2_PCM_BIT  = 0;
  localparam int unsigned CTRL_FSEL_BIT = 0;
  localparam int unsigned CTRL_W8_BIT   = 1;
  localparam int unsigned CTRL_REP_LSB  = 4;
  localparam int unsigned STAT_OK_BIT   = 0;
  localparam int unsigned STAT_PH_LSB   = 4;
  localparam int unsigned STAT_CNT_LSB  = 16;
  localparam int unsigned EV_OFF        = 0;
  localparam int unsigned EV_DONE       = 1;
  localparam int unsigned EV_WORD       = 2;

  // Values after reset
  localparam logic [2:0]  RST_ST_REP  = 3'h1;
  localparam logic [7:0]  RST_MONLIM  = 8'h10;
  localparam logic [15:0] RST_STEP    = 16'h0001;
  localparam logic [15:0] RST_RATE    = 16'h0001;
  localparam logic [25:0] RST_OFFLIM  = 26'h0100000;

  typedef enum logic [3:0] {
    AOCOS_PH1  = 4'h1,
    AOCOS_PH2  = 4'h2,
    AOCOS_ST   = 4'h4,
    AOCOS_DONE = 4'h8
  } aocos_phase_type;

endpackage : aocos_pkg

// ==== design/aocos_top.sv ====
// Overview of operation
// - Startup: 10 Hz 80 ms, 0.3 Hz 70 ms, unlimited
// - Completed: selected normal filter, rate limiting on
// - Self-test freezes offset output, 96 ms, <=6 repeats
// - Correction moves at most step per interval
// - First-order IIR offset filter with given coefficients
// - Monitor counts up outside limits, down inside
// - Count above limit clears offset-valid flag
// - Monitor counter saturates, never wraps
// - Monitor idle during all startup phases
// - Samples delayed one period, 16:1 interpolation
// - Sync interpolates two latest samples into word
// - Clip 26-bit result to 10- or 8-bit word
// - Round bits 21:12 or 21:14
// - Test output driven only while enable set
// - 4 MHz pulse code of upper nine bits
// - Two-bit low-pass select field in config
//
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module aocos_top #(
  parameter int unsigned PH1_CYC = aocos_pkg::PH1_CYC,
  parameter int unsigned PH2_CYC = aocos_pkg::PH2_CYC,
  parameter int unsigned ST_CYC  = aocos_pkg::ST_CYC,
  parameter int unsigned MON_W   = aocos_pkg::MON_W
) (
  input  wire logic               clk,
  input  wire logic               srst,
  input  wire logic [7:0]         addr,
  input  wire logic [31:0]        wdata,
  input  wire logic               wr_en,
  input  wire logic               rd_en,
  output logic      [31:0]        rdata,
  input  wire logic signed [25:0] sample_in,
  input  wire logic               sample_valid,
  input  wire logic               sync_valid,
  output logic      [9:0]         acc_word,
  output logic                    acc_word_valid,
  output logic      [1:0]         lowpass_select_field,
  output logic                    irq,
  output logic                    pcm_out,
  output logic                    pcm_oe
);
  localparam int unsigned YW = aocos_pkg::YW;
  localparam logic [MON_W-1:0] MONITOR_COUNTER_MAX = '1;
  typedef struct packed {
    aocos_pkg::aocos_phase_type phase;
    logic [aocos_pkg::PHW-1:0]  ph_cnt;
    logic [2:0]                 st_left;
    logic [2:0]                 st_rep;
    logic                       pcm_en;
    logic [1:0]                 lp_sel;
    logic                       filt_sel;
    logic                       word8;
    logic [2:0]                 mask;
    logic [2:0]                 irq_st;
    logic [MON_W-1:0]           mon_lim;
    logic [MON_W-1:0]           mon_cnt;
    logic                       off_valid;
    logic [15:0]                step;
    logic [15:0]                rate;
    logic [15:0]                rate_cnt;
    logic [25:0]                off_lim;
    logic signed [25:0]         x1;
    logic signed [YW-1:0]       y;
    logic signed [25:0]         off_out;
    logic signed [25:0]         cur;
    logic signed [25:0]         prev;
    logic [3:0]                 sub_ph;
    logic [7:0]                 sub_cnt;
    logic [9:0]                 word;
    logic                       word_v;
    logic [31:0]                rdata;
    logic [4:0]                 pcm_cnt;
    logic [8:0]                 pcm_acc;
    logic                       pcm_out;
    logic                       pcm_oe;
    logic                       irq;
  } aocos_state_type;
  aocos_state_type s;
  aocos_state_type n;
  function automatic logic [aocos_pkg::PHW-1:0] last_cyc(
    input int unsigned c
  );
    return aocos_pkg::PHW'(c - 1);
  endfunction : last_cyc
  function automatic logic signed [25:0] sat26(
    input logic signed [26:0] v
  );
    if (v > 27'sh1ffffff)
      return 26'sh1ffffff;
    else if (v < -27'sh2000000)
      return -26'sh2000000;
    return v[25:0];
  endfunction : sat26
  // y = a*(x + x1)/2 + b*y1; the half taps become one shift
  function automatic logic signed [YW-1:0] iir_step(
    input logic signed [25:0]    a,
    input logic signed [25:0]    b,
    input logic signed [25:0]    x,
    input logic signed [25:0]    xp,
    input logic signed [YW-1:0]  yp
  );
    logic signed [79:0] ta;
    logic signed [79:0] tb;
    ta = 80'(a) * 80'(27'(x) + 27'(xp));
    tb = 80'(b) * 80'(yp);
    return YW'(((ta <<< (aocos_pkg::YF - 1)) + tb) >>> aocos_pkg::COEF_FRAC);
  endfunction : iir_step
  function automatic logic signed [25:0] interp(
    input logic signed [25:0] a,
    input logic signed [25:0] b,
    input logic [3:0]         ph
  );
    logic signed [31:0] d;
    d = (32'(b) - 32'(a)) * $signed({28'h0, ph});
    return 26'(32'(a) + (d >>> 4));
  endfunction : interp
  function automatic logic [9:0] scale_word(
    input logic signed [25:0] v,
    input logic               w8
  );
    logic signed [26:0] r;
    r = '0;
    if (w8) begin
      r = (27'(v) + (27'sh1 <<< (aocos_pkg::LSB8 - 1))) >>> aocos_pkg::LSB8;
      if (r > 27'sh7f)
        r = 27'sh7f;
      else if (r < -27'sh80)
        r = -27'sh80;
    end else begin
      r = (27'(v) + (27'sh1 <<< (aocos_pkg::LSB10 - 1))) >>> aocos_pkg::LSB10;
      if (r > 27'sh1ff)
        r = 27'sh1ff;
      else if (r < -27'sh200)
        r = -27'sh200;
    end
    return r[9:0];
  endfunction : scale_word
  logic signed [25:0]   coef_a;
  logic signed [25:0]   coef_b;
  logic signed [YW-1:0] y_new;
  logic signed [25:0]   y_int;
  logic                 outside;
  // Coefficients follow the startup phase
  always_comb begin
    case (s.phase)
      aocos_pkg::AOCOS_PH1: begin
        coef_a = aocos_pkg::A_10HZ;
        coef_b = aocos_pkg::B_10HZ;
      end
      aocos_pkg::AOCOS_DONE: begin
        coef_a = s.filt_sel ? aocos_pkg::A_0P3HZ : aocos_pkg::A_0P1HZ;
        coef_b = s.filt_sel ? aocos_pkg::B_0P3HZ : aocos_pkg::B_0P1HZ;
      end
      default: begin
        coef_a = aocos_pkg::A_0P3HZ;
        coef_b = aocos_pkg::B_0P3HZ;
      end
    endcase
  end
  assign y_new   = iir_step(coef_a, coef_b, sample_in, s.x1, s.y);
  assign y_int   = 26'(y_new >>> aocos_pkg::YF);
  assign outside = (27'(y_int) > $signed({1'b0, s.off_lim})) ||
                   (27'(y_int) < -$signed({1'b0, s.off_lim}));
  always_comb begin
    logic [2:0]         ev;
    logic [2:0]         w1c;
    logic signed [26:0] diff;
    logic signed [26:0] stp;
    logic [9:0]         pcm_sum;
    n       = s;
    ev      = '0;
    w1c     = '0;
    diff    = '0;
    stp     = $signed({11'h0, s.step});
    pcm_sum = '0;
    n.word_v = 1'b0;
    n.rdata  = '0;
    if (wr_en) begin
      case (addr)
        aocos_pkg::ADDR_CFG2: n.pcm_en = wdata[aocos_pkg::CFG2_PCM_BIT];
        aocos_pkg::ADDR_CFG3: n.lp_sel = wdata[1:0];
        aocos_pkg::ADDR_CTRL: begin
          n.filt_sel = wdata[aocos_pkg::CTRL_FSEL_BIT];
          n.word8    = wdata[aocos_pkg::CTRL_W8_BIT];
          n.st_rep   = wdata[aocos_pkg::CTRL_REP_LSB +: 3];
          if (n.st_rep > 3'(aocos_pkg::ST_MAX_REPEAT))
            n.st_rep = 3'(aocos_pkg::ST_MAX_REPEAT);
        end
        aocos_pkg::ADDR_IRQ:    w1c = wdata[2:0];
        aocos_pkg::ADDR_MASK:   n.mask = wdata[2:0];
        aocos_pkg::ADDR_MONLIM: n.mon_lim = wdata[MON_W-1:0];
        aocos_pkg::ADDR_STEP:   n.step = wdata[15:0];
        aocos_pkg::ADDR_RATE:   n.rate = wdata[15:0];
        aocos_pkg::ADDR_OFFLIM: n.off_lim = wdata[25:0];
        default: ;
      endcase
    end
    // Startup sequencer, counted from reset release
    n.ph_cnt = s.ph_cnt + 1'b1;
    case (s.phase)
      aocos_pkg::AOCOS_PH1: begin
        if (s.ph_cnt == last_cyc(PH1_CYC)) begin
          n.phase  = aocos_pkg::AOCOS_PH2;
          n.ph_cnt = '0;
        end
      end
      aocos_pkg::AOCOS_PH2: begin
        if (s.ph_cnt == last_cyc(PH2_CYC)) begin
          n.ph_cnt = '0;
          if (s.st_rep != 3'h0) begin
            n.phase   = aocos_pkg::AOCOS_ST;
            n.st_left = s.st_rep - 3'h1;
          end else begin
            n.phase     = aocos_pkg::AOCOS_DONE;
            ev[aocos_pkg::EV_DONE] = 1'b1;
          end
        end
      end
      aocos_pkg::AOCOS_ST: begin
        if (s.ph_cnt == last_cyc(ST_CYC)) begin
          n.ph_cnt = '0;
          if (s.st_left == 3'h0) begin
            n.phase = aocos_pkg::AOCOS_DONE;
            ev[aocos_pkg::EV_DONE] = 1'b1;
          end else begin
            n.st_left = s.st_left - 3'h1;
          end
        end
      end
      aocos_pkg::AOCOS_DONE: n.ph_cnt = s.ph_cnt;
      default: begin
        n.phase  = aocos_pkg::AOCOS_PH1;
        n.ph_cnt = '0;
      end
    endcase
    if (sample_valid) begin
      n.y  = y_new;
      n.x1 = sample_in;
      case (s.phase)
        aocos_pkg::AOCOS_PH1, aocos_pkg::AOCOS_PH2: n.off_out = y_int;
        aocos_pkg::AOCOS_DONE: begin
          // Slow walk keeps a late offset jump from looking like a pulse
          if ((s.rate_cnt + 16'h1) >= s.rate) begin
            n.rate_cnt = '0;
            diff = 27'(y_int) - 27'(s.off_out);
            if (diff > stp)
              n.off_out = sat26(27'(s.off_out) + stp);
            else if (diff < -stp)
              n.off_out = sat26(27'(s.off_out) - stp);
            else
              n.off_out = y_int;
          end else begin
            n.rate_cnt = s.rate_cnt + 16'h1;
          end
          if (outside) begin
            if (s.mon_cnt != MONITOR_COUNTER_MAX)
              n.mon_cnt = s.mon_cnt + 1'b1;
          end else if (s.mon_cnt != '0) begin
            n.mon_cnt = s.mon_cnt - 1'b1;
          end
          if (n.mon_cnt > s.mon_lim && s.off_valid) begin
            n.off_valid = 1'b0;
            ev[aocos_pkg::EV_OFF] = 1'b1;
          end
        end
        default: ;
      endcase
      n.prev    = s.cur;
      n.cur     = sat26(27'(sample_in) - 27'(s.off_out));
      n.sub_ph  = '0;
      n.sub_cnt = '0;
    end else if (s.sub_cnt == 8'(aocos_pkg::STEP_CYC - 1)) begin
      n.sub_cnt = '0;
      if (s.sub_ph != 4'hf)
        n.sub_ph = s.sub_ph + 4'h1;
    end else begin
      n.sub_cnt = s.sub_cnt + 8'h1;
    end
    if (sync_valid) begin
      n.word   = scale_word(interp(s.prev, s.cur, s.sub_ph), s.word8);
      n.word_v = 1'b1;
      ev[aocos_pkg::EV_WORD] = 1'b1;
    end
    // First-order pulse density modulator on the offset-binary word
    if (s.pcm_cnt == 5'(aocos_pkg::PCM_CYC - 1)) begin
      n.pcm_cnt = '0;
      pcm_sum   = {1'b0, s.pcm_acc} + {1'b0, ~s.word[9], s.word[8:1]};
      n.pcm_acc = pcm_sum[8:0];
      n.pcm_out = pcm_sum[9];
    end else begin
      n.pcm_cnt = s.pcm_cnt + 5'h1;
    end
    n.pcm_oe = s.pcm_en;
    if (!s.pcm_en)
      n.pcm_out = 1'b0;
    // A new event wins over a clear in the same cycle
    n.irq_st = (s.irq_st & ~w1c) | ev;
    n.irq    = |(n.irq_st & n.mask);
    if (rd_en) begin
      case (addr)
        aocos_pkg::ADDR_CFG2: n.rdata = {31'h0, s.pcm_en};
        aocos_pkg::ADDR_CFG3: n.rdata = {30'h0, s.lp_sel};
        aocos_pkg::ADDR_CTRL: begin
          n.rdata[aocos_pkg::CTRL_FSEL_BIT]     = s.filt_sel;
          n.rdata[aocos_pkg::CTRL_W8_BIT]       = s.word8;
          n.rdata[aocos_pkg::CTRL_REP_LSB +: 3] = s.st_rep;
        end
        aocos_pkg::ADDR_STAT: begin
          n.rdata[aocos_pkg::STAT_OK_BIT]          = s.off_valid;
          n.rdata[aocos_pkg::STAT_PH_LSB +: 4]     = s.phase;
          n.rdata[aocos_pkg::STAT_CNT_LSB +: MON_W] = s.mon_cnt;
        end
        aocos_pkg::ADDR_IRQ:    n.rdata = {29'h0, s.irq_st};
        aocos_pkg::ADDR_MASK:   n.rdata = {29'h0, s.mask};
        aocos_pkg::ADDR_MONLIM: n.rdata[MON_W-1:0] = s.mon_lim;
        aocos_pkg::ADDR_STEP:   n.rdata = {16'h0, s.step};
        aocos_pkg::ADDR_RATE:   n.rdata = {16'h0, s.rate};
        aocos_pkg::ADDR_OFFLIM: n.rdata = {6'h0, s.off_lim};
        aocos_pkg::ADDR_DATA:   n.rdata = {22'h0, s.word};
        default:                n.rdata = '0;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      s           <= '0;
      s.phase     <= aocos_pkg::AOCOS_PH1;
      s.off_valid <= 1'b1;
      s.st_rep    <= aocos_pkg::RST_ST_REP;
      s.mon_lim   <= MON_W'(aocos_pkg::RST_MONLIM);
      s.step      <= aocos_pkg::RST_STEP;
      s.rate      <= aocos_pkg::RST_RATE;
      s.off_lim   <= aocos_pkg::RST_OFFLIM;
    end else begin
      s <= n;
    end
  end
  assign rdata                = s.rdata;
  assign acc_word             = s.word;
  assign acc_word_valid       = s.word_v;
  assign lowpass_select_field = s.lp_sel;
  assign irq                  = s.irq;
  assign pcm_out              = s.pcm_out;
  assign pcm_oe               = s.pcm_oe;
  default clocking cb_main @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_ph1_end;
    s.phase == aocos_pkg::AOCOS_PH1 && s.ph_cnt == last_cyc(PH1_CYC);
  endsequence
  sequence s_ph1_run;
    s.phase == aocos_pkg::AOCOS_PH1 && s.ph_cnt != last_cyc(PH1_CYC);
  endsequence
  sequence s_mon_rise;
    sample_valid && s.phase == aocos_pkg::AOCOS_DONE && outside &&
      s.mon_cnt >= s.mon_lim && s.mon_cnt != MONITOR_COUNTER_MAX;
  endsequence
  AST_PH1_END: assert property (s_ph1_end |=>
    s.phase == aocos_pkg::AOCOS_PH2 && s.ph_cnt == '0)
    else $error("phase one did not end at its length");
  AST_PH1_HOLD: assert property (s_ph1_run |=>
    s.phase == aocos_pkg::AOCOS_PH1)
    else $error("phase one left early");
  AST_BYPASS: assert property ((sample_valid &&
    s.phase == aocos_pkg::AOCOS_PH2) |=> s.off_out == $past(y_int))
    else $error("offset output not bypassed in phase two");
  AST_FROZEN: assert property (s.phase == aocos_pkg::AOCOS_ST |=>
    $stable(s.off_out))
    else $error("offset output moved during self-test");
  AST_RATE: assert property (s.phase == aocos_pkg::AOCOS_DONE |=>
    27'(s.off_out) - 27'($past(s.off_out)) <=
      $signed({11'h0, $past(s.step)}) &&
    27'(s.off_out) - 27'($past(s.off_out)) >=
      -$signed({11'h0, $past(s.step)}))
    else $error("offset correction stepped too far");
  AST_MON_IDLE: assert property (s.phase != aocos_pkg::AOCOS_DONE |=>
    $stable(s.mon_cnt) && s.off_valid)
    else $error("monitor active during startup");
  AST_MON_SAT: assert property ((sample_valid && outside &&
    s.phase == aocos_pkg::AOCOS_DONE &&
    s.mon_cnt == MONITOR_COUNTER_MAX) |=> s.mon_cnt == MONITOR_COUNTER_MAX)
    else $error("monitor counter wrapped");
  AST_MON_CLR: assert property (s_mon_rise |=> !s.off_valid ##1
    !s.off_valid)
    else $error("offset-valid flag not cleared");
  AST_DELAY: assert property (sample_valid |=> s.prev == $past(s.cur))
    else $error("sample not delayed by one period");
  AST_SYNC: assert property (sync_valid ##1 !sync_valid |->
    acc_word_valid ##1 !acc_word_valid)
    else $error("sync did not give one word strobe");
  AST_PCM_OFF: assert property (!s.pcm_en |=> !pcm_oe && !pcm_out)
    else $error("test output driven while disabled");
endmodule : aocos_top

// ==== bench/aocos_tb.sv ====
`timescale 1ns/1ps
module tb;
  logic               clk = 1'b0;
  logic               srst = 1'b1;
  logic [7:0]         addr = 8'h00;
  logic [31:0]        wdata = 32'h0;
  logic               wr_en = 1'b0;
  logic               rd_en = 1'b0;
  logic [31:0]        rdata;
  logic signed [25:0] sample_in = 26'sh0;
  logic               sample_valid = 1'b0;
  logic               sync_valid = 1'b0;
  logic [9:0]         acc_word;
  logic               acc_word_valid;
  logic [1:0]         lowpass_select_field;
  logic               irq;
  logic               pcm_out;
  logic               pcm_oe;
  int                 n_fail = 0;
  int                 checks_done = 0;
  int                 cyc = 0;
  int                 t0 = 0;
  int                 seed = 32'ha4c5;
  int                 hi = 0;
  int                 u = 0;
  longint             hist[$];
  logic [31:0]        d;

  always #4 clk = ~clk;

  // Short startup phases keep the run small
  aocos_top #(.PH1_CYC(200), .PH2_CYC(150), .ST_CYC(100)) uut (
    .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .sample_in(sample_in),
    .sample_valid(sample_valid), .sync_valid(sync_valid),
    .acc_word(acc_word), .acc_word_valid(acc_word_valid),
    .lowpass_select_field(lowpass_select_field), .irq(irq),
    .pcm_out(pcm_out), .pcm_oe(pcm_oe));

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      n_fail++;
      $display("mismatch at %0t: run timed out", $time);
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk(rdata, exp, "register read");
  endtask : rchk

  task automatic smp(input longint v);
    @(posedge clk);
    sample_in <= v[25:0];
    sample_valid <= 1'b1;
    @(posedge clk);
    sample_valid <= 1'b0;
    hist.push_back(v);
  endtask : smp

  function automatic logic [9:0] model(input int ph, input bit w8);
    longint p;
    longint c;
    longint v;
    longint r;
    longint lim;
    p = hist[$-1];
    c = hist[$];
    v = p + (((c - p) * ph) >>> 4);
    lim = w8 ? 127 : 511;
    r = w8 ? ((v + 8192) >>> 14) : ((v + 2048) >>> 12);
    if (r > lim) r = lim;
    if (r < -lim - 1) r = -lim - 1;
    return r[9:0];
  endfunction : model

  task automatic syn(input int ph, input bit w8);
    logic [9:0] e;
    e = model(ph, w8);
    @(posedge clk);
    sync_valid <= 1'b1;
    @(posedge clk);
    sync_valid <= 1'b0;
    #1 chk({31'h0, acc_word_valid}, 32'h1, "word valid");
    chk({22'h0, acc_word}, {22'h0, e}, "word value");
  endtask : syn

  task automatic till(input int n);
    while (cyc - t0 < n) @(posedge clk);
  endtask : till

  // Interpolation at both ends of the sub-sample range
  task automatic interp(input bit w8, input int n);
    for (int i = 0; i < n; i++) begin
      smp((i % 2) ? ($random(seed) >>> 7) : ($random(seed) >>> 10));
      syn(0, w8);
      repeat (2100) @(posedge clk);
      syn(15, w8);
    end
    syn(15, w8);
  endtask : interp

  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    t0 = cyc;
    #1 chk({18'h0, acc_word, irq, pcm_oe, pcm_out, acc_word_valid}, 0, "rst");
    rchk(aocos_pkg::ADDR_CFG2, 32'h0);
    rchk(aocos_pkg::ADDR_CFG3, 32'h0);
    rchk(aocos_pkg::ADDR_CTRL, 32'h10);
    rchk(aocos_pkg::ADDR_MASK, 32'h0);
    rchk(aocos_pkg::ADDR_MONLIM, 32'h10);
    rchk(aocos_pkg::ADDR_STEP, 32'h1);
    rchk(aocos_pkg::ADDR_RATE, 32'h1);
    rchk(aocos_pkg::ADDR_OFFLIM, 32'h100000);
    rchk(8'h30, 32'h0);
    rchk(aocos_pkg::ADDR_STAT, 32'h11);
    // A zero step freezes the offset at zero, so words follow samples
    wr(aocos_pkg::ADDR_STEP, 32'h0);
    // Zero samples in the bypassed phases keep the offset at zero
    smp(0);
    till(275);
    rchk(aocos_pkg::ADDR_STAT, 32'h21);
    smp(0);
    till(400);
    rchk(aocos_pkg::ADDR_STAT, 32'h41);
    // Self-test sample moves the filter but not the frozen offset
    smp($random(seed) >>> 8);
    till(500);
    rchk(aocos_pkg::ADDR_STAT, 32'h81);
    rchk(aocos_pkg::ADDR_IRQ, 32'h2);
    $display("test startup done");
    smp($random(seed) >>> 9);
    repeat (2100) @(posedge clk);
    interp(1'b0, 8);
    rchk(aocos_pkg::ADDR_DATA, {22'h0, model(15, 1'b0)});
    wr(aocos_pkg::ADDR_CTRL, 32'h73);
    rchk(aocos_pkg::ADDR_CTRL, 32'h63);
    interp(1'b1, 4);
    wr(aocos_pkg::ADDR_CTRL, 32'h0);
    $display("test interpolation done");
    wr(aocos_pkg::ADDR_IRQ, 32'h7);
    rchk(aocos_pkg::ADDR_IRQ, 32'h0);
    wr(aocos_pkg::ADDR_MASK, 32'h4);
    syn(15, 1'b0);
    repeat (3) @(posedge clk);
    #1 chk({31'h0, irq}, 32'h1, "irq raised");
    wr(aocos_pkg::ADDR_IRQ, 32'h4);
    repeat (3) @(posedge clk);
    #1 chk({31'h0, irq}, 32'h0, "irq cleared");
    wr(aocos_pkg::ADDR_MASK, 32'h0);
    syn(15, 1'b0);
    repeat (3) @(posedge clk);
    #1 chk({31'h0, irq}, 32'h0, "irq masked");
    $display("test interrupt done");
    for (int k = 0; k < 4; k++) begin
      wr(aocos_pkg::ADDR_CFG3, k);
      repeat (2) @(posedge clk);
      #1 chk({30'h0, lowpass_select_field}, k, "lowpass");
    end
    hi = 0;
    repeat (200) @(negedge clk) hi += pcm_out;
    chk({31'h0, pcm_oe}, 32'h0, "pcm oe off");
    chk(hi, 0, "pcm idle");
    wr(aocos_pkg::ADDR_CFG2, 32'h1);
    repeat (3) @(posedge clk);
    #1 chk({31'h0, pcm_oe}, 32'h1, "pcm oe on");
    u = {~acc_word[9], acc_word[8:1]};
    hi = 0;
    repeat (1984) @(negedge clk) hi += pcm_out;
    // Density of ones over 64 ticks, two ticks of slack for the start
    u = u * 1984 / 512;
    chk({31'h0, hi <= u + 62 && hi + 62 >= u}, 32'h1, "pcm density");
    wr(aocos_pkg::ADDR_CFG2, 32'h0);
    repeat (35) @(posedge clk);
    #1 chk({30'h0, pcm_oe, pcm_out}, 32'h0, "pcm off");
    $display("test config done");
    wr(aocos_pkg::ADDR_IRQ, 32'h7);
    smp(26'sh0ffffff);
    smp(26'sh0ffffff);
    wr(aocos_pkg::ADDR_MONLIM, 32'h2);
    wr(aocos_pkg::ADDR_OFFLIM, 32'h0);
    repeat (2) smp(26'sh0ffffff);
    repeat (5) @(posedge clk);
    rchk(aocos_pkg::ADDR_STAT, 32'h020081);
    smp(26'sh0ffffff);
    repeat (5) @(posedge clk);
    rchk(aocos_pkg::ADDR_STAT, 32'h030080);
    rchk(aocos_pkg::ADDR_IRQ, 32'h1);
    for (int i = 0; i < 256; i++) begin
      smp(26'sh0ffffff);
      repeat (4) @(posedge clk);
    end
    rchk(aocos_pkg::ADDR_STAT, 32'hff0080);
    $display("test monitor done");
    print_verdict();
  end
endmodule : tb
